// file: design/reset_watchdog_interrupt_control.sv
// Contract
// - leaving reset, load pc from vector at fffe (high) then ffff (low)
// - during reset peripherals disabled and pins default high-z inputs
// - reset sets the global interrupt mask bit
// - reset forces stack pointer to 00ff
// - cause register keeps one bit per reset source, none for debug reset
// - any reset drives reset pin low 34 bus cycles, then releases it
// - 38 cycles after release sample pin; low means pin caused reset
// - enabled watchdog reaching timeout unserviced forces full reset
// - write to cause register address clears watchdog, cause unchanged
// - every reset leaves the watchdog enabled
// - options register write-once; later writes ignored until reset
// - timeout select picks 2^18 or 2^20 bus cycles
// - background debug mode suspends watchdog
// - flag plus local enable plus clear mask bit makes a request
// - interrupt entry waits for the current instruction to finish
// - entry stacks, sets mask, fetches vector, prefetches three bytes
// - hardware entry uses the software interrupt sequence exactly
// - return restores ccr, a, x low and pc from stack
// - index high byte never stacked or restored
// - several pending: highest priority served first
// - illegal address resets only small variants; illegal opcode always
// - stacking pcl first, ccr last; sp ends one below saved ccr
`include "sysctl_consts.svh"
module reset_watchdog_interrupt_control #(
   parameter int NSRC               = 8,
   parameter int COP_SHORT          = `COP_SHORT_CYC,
   parameter int COP_LONG           = `COP_LONG_CYC,
   parameter bit ILLEGAL_ADDR_RESET = 1'b1
) (
   input  wire logic            clk_i,
   input  wire logic            rst_n_i,
   input  wire logic [7:0]      avs_address_i,
   input  wire logic            avs_read_i,
   input  wire logic            avs_write_i,
   input  wire logic [31:0]     avs_writedata_i,
   output logic      [31:0]     avs_readdata_o,
   output logic                 avs_waitrequest_o,
   input  wire logic [15:0]     core_pc_i,
   input  wire logic [15:0]     core_sp_i,
   input  wire logic [7:0]      core_ccr_i,
   input  wire logic [7:0]      core_a_i,
   input  wire logic [7:0]      core_x_i,
   input  wire logic            instr_done_i,
   input  wire logic            swi_i,
   input  wire logic            rti_i,
   input  wire logic            illegal_op_i,
   input  wire logic            illegal_addr_i,
   input  wire logic            bdm_active_i,
   input  wire logic            bdm_reset_i,
   input  wire logic            lvd_i,
   input  wire logic            rst_pin_i,
   input  wire logic [NSRC-1:0] src_event_i,
   input  wire logic [7:0]      mem_rdata_i,
   output logic                 rst_pin_o,
   output logic                 rst_pin_oe_n_o,
   output logic                 reset_active_o,
   output logic                 core_hold_o,
   output logic                 core_load_o,
   output logic      [15:0]     core_pc_o,
   output logic      [15:0]     core_sp_o,
   output logic      [7:0]      core_ccr_o,
   output logic      [7:0]      core_a_o,
   output logic      [7:0]      core_x_o,
   output logic      [7:0]      pf_data_o,
   output logic                 pf_valid_o,
   output logic      [15:0]     mem_addr_o,
   output logic      [7:0]      mem_wdata_o,
   output logic                 mem_we_o,
   output logic                 mem_re_o
);
   localparam logic [20:0] LIM_S = 21'(COP_SHORT);
   localparam logic [20:0] LIM_L = 21'(COP_LONG);

   sysctl_pkg::ctl_state_type  st_ff;
   sysctl_pkg::ctl_state_type  nxt;
   logic [`SRC_MAX-1:0]        ev_ext;
   logic [`SRC_MAX-1:0]        src_ok;
   logic [`SRC_MAX-1:0]        pend;
   logic [`SRC_MAX-1:0]        clr;
   logic [`SRC_IDX_W-1:0]      win;
   logic [15:0]                irq_vec;
   logic [15:0]                base;
   logic [20:0]                lim;
   logic [5:0]                 new_cause;
   logic [7:0]                 opt_rd;
   logic                       in_rst;
   logic                       wr_cyc;
   logic                       svc_wr;
   logic                       opt_wr;
   logic                       cop_hit;
   logic                       req_ok;
   logic                       trig;

   // unused source slots read as never firing and cannot be enabled
   for (genvar g = 0; g < `SRC_MAX; g++) begin : g_src
      if (g < NSRC) begin : g_on
         assign ev_ext[g] = src_event_i[g];
         assign src_ok[g] = 1'b1;
      end else begin : g_off
         assign ev_ext[g] = 1'b0;
         assign src_ok[g] = 1'b0;
      end
   end

   always_comb begin
      nxt = st_ff;
      nxt.load = 1'b0;
      nxt.pf_valid = 1'b0;
      nxt.mem_we = 1'b0;
      nxt.mem_re = 1'b0;
      nxt.lvd_sync = {st_ff.lvd_sync[0], lvd_i};
      nxt.pin_sync = {st_ff.pin_sync[0], rst_pin_i};
      in_rst = st_ff.state inside {sysctl_pkg::S_RST_DRIVE, sysctl_pkg::S_RST_WAIT,
                                   sysctl_pkg::S_RST_VEC};

      // bus slave: one wait cycle, write lands on the edge waitrequest is low
      wr_cyc = avs_write_i && !st_ff.wait_req;
      svc_wr = wr_cyc && avs_address_i[7:2] == `REG_CAUSE;
      opt_wr = wr_cyc && avs_address_i[7:2] == `REG_OPT;
      nxt.wait_req = !((avs_read_i || avs_write_i) && st_ff.wait_req);
      opt_rd = 8'h00;
      opt_rd[`OPT_EN_BIT] = st_ff.opt_en;
      opt_rd[`OPT_TSEL_BIT] = st_ff.opt_tsel;
      opt_rd[`OPT_LOCK_BIT] = st_ff.opt_lock;
      if (avs_read_i && st_ff.wait_req) begin
         unique case (avs_address_i[7:2])
            `REG_CAUSE: nxt.rdata = {26'h0, st_ff.cause};
            `REG_OPT:   nxt.rdata = {24'h0, opt_rd};
            `REG_FLAG:  nxt.rdata = {16'h0, st_ff.flag};
            `REG_IEN:   nxt.rdata = {16'h0, st_ff.ien};
            `REG_STAT:  nxt.rdata = {30'h0, st_ff.opt_en && !bdm_active_i, st_ff.hold};
            default:    nxt.rdata = 32'h0;
         endcase
      end
      if (opt_wr && !st_ff.opt_lock) begin
         nxt.opt_en = avs_writedata_i[`OPT_EN_BIT];
         nxt.opt_tsel = avs_writedata_i[`OPT_TSEL_BIT];
         nxt.opt_lock = 1'b1;
      end
      if (wr_cyc && avs_address_i[7:2] == `REG_IEN) begin
         nxt.ien = avs_writedata_i[`SRC_MAX-1:0] & src_ok;
      end

      // flags: a new event beats a same-cycle write-one-to-clear
      clr = (wr_cyc && avs_address_i[7:2] == `REG_FLAG) ? avs_writedata_i[`SRC_MAX-1:0] : '0;
      nxt.flag = (st_ff.flag & ~clr) | ev_ext;
      pend = st_ff.flag & st_ff.ien;
      req_ok = |pend && !core_ccr_i[`CCR_I_BIT];
      win = '0;
      for (int i = `SRC_MAX - 1; i >= 0; i--) begin
         if (pend[i]) win = i[`SRC_IDX_W-1:0];
      end
      irq_vec = `VEC_SRC0 - 16'({win, 1'b0});

      // watchdog
      lim = st_ff.opt_tsel ? LIM_L : LIM_S;
      cop_hit = st_ff.opt_en && !bdm_active_i && !in_rst && st_ff.wdog == lim - 21'h1;
      if (svc_wr) begin
         nxt.wdog = 21'h0;
      end else if (st_ff.opt_en && !bdm_active_i && !in_rst) begin
         nxt.wdog = st_ff.wdog + 21'h1;
      end

      // reset sources; the pin gets its bit only at the late sample
      new_cause = 6'h00;
      new_cause[`CAUSE_LVD] = st_ff.lvd_sync[1];
      new_cause[`CAUSE_COP] = cop_hit;
      new_cause[`CAUSE_ILOP] = illegal_op_i;
      new_cause[`CAUSE_ILAD] = illegal_addr_i && ILLEGAL_ADDR_RESET;
      trig = !in_rst && (|new_cause || !st_ff.pin_sync[1] || bdm_reset_i);

      base = 16'h0000;
      if (st_ff.state == sysctl_pkg::S_RST_VEC) base = `VEC_RESET;
      else if (st_ff.state == sysctl_pkg::S_VEC) base = st_ff.vec;
      else if (st_ff.state == sysctl_pkg::S_PREFETCH) base = st_ff.pc;
      else if (st_ff.state == sysctl_pkg::S_POP) base = st_ff.sp + 16'h0001;

      unique case (st_ff.state)
         sysctl_pkg::S_IDLE: begin
            // requests are only looked at on an instruction boundary
            if (instr_done_i && (swi_i || req_ok)) begin
               nxt.state = sysctl_pkg::S_STACK;
               nxt.vec = swi_i ? `VEC_SWI : irq_vec;
               nxt.pc = core_pc_i;
               nxt.sp = core_sp_i;
               nxt.condition_code_register = core_ccr_i;
               nxt.acc = core_a_i;
               nxt.xlo = core_x_i;
               nxt.cnt = 8'h00;
               nxt.hold = 1'b1;
            end else if (instr_done_i && rti_i) begin
               nxt.state = sysctl_pkg::S_POP;
               nxt.sp = core_sp_i;
               nxt.cnt = 8'h00;
               nxt.phase = 2'h0;
               nxt.hold = 1'b1;
            end
         end
         sysctl_pkg::S_RST_DRIVE: begin
            nxt.cnt = st_ff.cnt + 8'h01;
            if (st_ff.cnt == `RST_DRIVE_CYC - 8'h01) begin
               nxt.pin_oe_n = 1'b1;
               nxt.state = sysctl_pkg::S_RST_WAIT;
               nxt.cnt = 8'h00;
            end
         end
         sysctl_pkg::S_RST_WAIT: begin
            // held here while the pin or low voltage still asserts
            if (st_ff.cnt == `RST_SAMPLE_CYC - 8'h01) begin
               if (!st_ff.pin_sync[1]) nxt.cause[`CAUSE_PIN] = 1'b1;
               if (st_ff.pin_sync[1] && !st_ff.lvd_sync[1]) begin
                  nxt.state = sysctl_pkg::S_RST_VEC;
                  nxt.cnt = 8'h00;
                  nxt.phase = 2'h0;
               end
            end else begin
               nxt.cnt = st_ff.cnt + 8'h01;
            end
         end
         sysctl_pkg::S_STACK: begin
            nxt.mem_we = 1'b1;
            nxt.mem_addr = st_ff.sp - 16'(st_ff.cnt);
            unique case (st_ff.cnt[2:0])
               3'h0:    nxt.mem_wdata = st_ff.pc[7:0];
               3'h1:    nxt.mem_wdata = st_ff.pc[15:8];
               3'h2:    nxt.mem_wdata = st_ff.xlo;
               3'h3:    nxt.mem_wdata = st_ff.acc;
               default: nxt.mem_wdata = st_ff.condition_code_register;
            endcase
            nxt.cnt = st_ff.cnt + 8'h01;
            if (st_ff.cnt == 8'h04) begin
               nxt.state = sysctl_pkg::S_VEC;
               nxt.sp = st_ff.sp - 16'h0005;
               nxt.condition_code_register[`CCR_I_BIT] = 1'b1;
               nxt.cnt = 8'h00;
               nxt.phase = 2'h0;
            end
         end
         sysctl_pkg::S_RST_VEC, sysctl_pkg::S_VEC,
         sysctl_pkg::S_PREFETCH, sysctl_pkg::S_POP: begin
            // read: issue, memory samples, capture on the third edge
            unique case (st_ff.phase)
               2'h0: begin
                  nxt.mem_re = 1'b1;
                  nxt.mem_addr = base + 16'(st_ff.cnt);
                  nxt.phase = 2'h1;
               end
               2'h1: nxt.phase = 2'h2;
               default: begin
                  nxt.phase = 2'h0;
                  nxt.cnt = st_ff.cnt + 8'h01;
                  if (st_ff.state == sysctl_pkg::S_PREFETCH) begin
                     nxt.pf_data = mem_rdata_i;
                     nxt.pf_valid = 1'b1;
                     if (st_ff.cnt == 8'h02) begin
                        nxt.state = sysctl_pkg::S_IDLE;
                        nxt.load = 1'b1;
                        nxt.hold = 1'b0;
                     end
                  end else if (st_ff.state == sysctl_pkg::S_POP) begin
                     unique case (st_ff.cnt[2:0])
                        3'h0:    nxt.condition_code_register = mem_rdata_i;
                        3'h1:    nxt.acc = mem_rdata_i;
                        3'h2:    nxt.xlo = mem_rdata_i;
                        3'h3:    nxt.pc[15:8] = mem_rdata_i;
                        default: begin
                           nxt.pc[7:0] = mem_rdata_i;
                           nxt.sp = st_ff.sp + 16'h0005;
                           nxt.state = sysctl_pkg::S_PREFETCH;
                           nxt.cnt = 8'h00;
                        end
                     endcase
                  end else if (st_ff.cnt == 8'h00) begin
                     nxt.pc[15:8] = mem_rdata_i;
                  end else begin
                     nxt.pc[7:0] = mem_rdata_i;
                     nxt.cnt = 8'h00;
                     if (st_ff.state == sysctl_pkg::S_VEC) begin
                        nxt.state = sysctl_pkg::S_PREFETCH;
                     end else begin
                        nxt.state = sysctl_pkg::S_IDLE;
                        nxt.sp = `SP_RESET;
                        nxt.condition_code_register = `CCR_RESET;
                        nxt.acc = 8'h00;
                        nxt.xlo = 8'h00;
                        nxt.load = 1'b1;
                        nxt.hold = 1'b0;
                        nxt.rst_active = 1'b0;
                     end
                  end
               end
            endcase
         end
      endcase

      if (!rst_n_i) begin
         nxt = '0;
         nxt.wait_req = 1'b1;
      end
      if (trig || !rst_n_i) begin
         nxt.state = sysctl_pkg::S_RST_DRIVE;
         nxt.cnt = 8'h00;
         nxt.phase = 2'h0;
         nxt.wdog = 21'h0;
         nxt.opt_en = `OPT_EN_RST;
         nxt.opt_tsel = `OPT_TSEL_RST;
         nxt.opt_lock = 1'b0;
         nxt.flag = '0;
         nxt.ien = '0;
         nxt.pin_oe_n = 1'b0;
         nxt.rst_active = 1'b1;
         nxt.hold = 1'b1;
         nxt.load = 1'b0;
         nxt.pf_valid = 1'b0;
         nxt.mem_we = 1'b0;
         nxt.mem_re = 1'b0;
         nxt.cause = new_cause;
         if (!rst_n_i) nxt.cause = 6'h00;
         nxt.cause[`CAUSE_POR] = !rst_n_i;
      end
   end

   always_ff @(posedge clk_i) begin
      st_ff <= nxt;
   end

   assign avs_readdata_o = st_ff.rdata;
   assign avs_waitrequest_o = st_ff.wait_req;
   // open-drain: only ever pulls low, the pullup lives outside
   assign rst_pin_o = 1'b0;
   assign rst_pin_oe_n_o = st_ff.pin_oe_n;
   assign reset_active_o = st_ff.rst_active;
   assign core_hold_o = st_ff.hold;
   assign core_load_o = st_ff.load;
   assign core_pc_o = st_ff.pc;
   assign core_sp_o = st_ff.sp;
   assign core_ccr_o = st_ff.condition_code_register;
   assign core_a_o = st_ff.acc;
   assign core_x_o = st_ff.xlo;
   assign pf_data_o = st_ff.pf_data;
   assign pf_valid_o = st_ff.pf_valid;
   assign mem_addr_o = st_ff.mem_addr;
   assign mem_wdata_o = st_ff.mem_wdata;
   assign mem_we_o = st_ff.mem_we;
   assign mem_re_o = st_ff.mem_re;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence five_writes_s;
      mem_we_o [*5] ##1 !mem_we_o;
   endsequence

   pin_drive_start_a: assert property ($fell(rst_pin_oe_n_o) |-> st_ff.cnt == 8'h00)
      else $error("reset pin drive did not start at count zero");
   pin_drive_len_a: assert property ($rose(rst_pin_oe_n_o) |->
      $past(st_ff.cnt) == `RST_DRIVE_CYC - 8'h01)
      else $error("reset pin drive length wrong");
   pin_sample_a: assert property (st_ff.state == sysctl_pkg::S_RST_WAIT &&
      st_ff.cnt == `RST_SAMPLE_CYC - 8'h01 && !st_ff.pin_sync[1] |=> st_ff.cause[`CAUSE_PIN])
      else $error("pin low at sample not recorded");
   periph_off_a: assert property (st_ff.state == sysctl_pkg::S_RST_DRIVE |-> reset_active_o)
      else $error("peripherals not held off in reset");
   reset_vec_a: assert property (st_ff.state == sysctl_pkg::S_RST_VEC &&
      st_ff.phase == 2'h0 && st_ff.cnt == 8'h00 |=> mem_re_o && mem_addr_o == `VEC_RESET)
      else $error("reset vector high byte not fetched first");
   reset_mask_a: assert property (core_load_o &&
      $past(st_ff.state) == sysctl_pkg::S_RST_VEC |-> core_ccr_o[`CCR_I_BIT])
      else $error("mask bit clear after reset");
   reset_sp_a: assert property (core_load_o &&
      $past(st_ff.state) == sysctl_pkg::S_RST_VEC |-> core_sp_o == `SP_RESET)
      else $error("stack pointer wrong after reset");
   stack_len_a: assert property ($rose(mem_we_o) |-> five_writes_s)
      else $error("stacking is not five writes");
   stack_addr_a: assert property ($rose(mem_we_o) |->
      ##4 mem_addr_o == $past(mem_addr_o, 4) - 16'h0004)
      else $error("stack frame addresses wrong");
   entry_mask_a: assert property (st_ff.state == sysctl_pkg::S_STACK &&
      st_ff.cnt == 8'h04 && !trig |=> st_ff.condition_code_register[`CCR_I_BIT] && st_ff.state == sysctl_pkg::S_VEC)
      else $error("mask not set on entry");
   cop_reset_a: assert property (cop_hit |=>
      st_ff.state == sysctl_pkg::S_RST_DRIVE && st_ff.cause[`CAUSE_COP])
      else $error("watchdog timeout gave no reset");
   cop_service_a: assert property (svc_wr && !trig |=>
      st_ff.wdog == 21'h0 && st_ff.cause == $past(st_ff.cause))
      else $error("watchdog service wrong");
   reset_defaults_a: assert property (trig |=> st_ff.opt_en && st_ff.wdog == 21'h0)
      else $error("reset did not re-enable watchdog");
   opt_once_a: assert property (opt_wr && st_ff.opt_lock && !trig |=>
      st_ff.opt_en == $past(st_ff.opt_en) && st_ff.opt_tsel == $past(st_ff.opt_tsel))
      else $error("locked options changed");
   bdm_freeze_a: assert property (bdm_active_i && !svc_wr && !trig |=>
      st_ff.wdog == $past(st_ff.wdog))
      else $error("watchdog ran in debug mode");
   masked_irq_a: assert property (st_ff.state == sysctl_pkg::S_IDLE &&
      instr_done_i && !swi_i && !rti_i && !req_ok && !trig |=> st_ff.state == sysctl_pkg::S_IDLE)
      else $error("unqualified interrupt taken");
endmodule

// file: design/sysctl_consts.svh
`ifndef SYSCTL_CONSTS_SVH
`define SYSCTL_CONSTS_SVH
`define RST_DRIVE_CYC  8'h22
`define RST_SAMPLE_CYC 8'h26
`define COP_SHORT_CYC  32'h0004_0000
`define COP_LONG_CYC   32'h0010_0000
`define VEC_RESET      16'hfffe
`define VEC_SWI        16'hfffc
`define VEC_SRC0       16'hfffa
`define SP_RESET       16'h00ff
`define CCR_RESET      8'h08
`define CCR_I_BIT      3
`define REG_CAUSE      6'h00
`define REG_OPT        6'h01
`define REG_FLAG       6'h02
`define REG_IEN        6'h03
`define REG_STAT       6'h04
`define CAUSE_POR      0
`define CAUSE_LVD      1
`define CAUSE_COP      2
`define CAUSE_ILOP     3
`define CAUSE_ILAD     4
`define CAUSE_PIN      5
`define OPT_EN_BIT     0
`define OPT_TSEL_BIT   1
`define OPT_LOCK_BIT   7
`define OPT_EN_RST     1'b1
`define OPT_TSEL_RST   1'b1
`define SRC_MAX        16
`define SRC_IDX_W      4
`endif

// file: design/sysctl_pkg.sv
`include "sysctl_consts.svh"
package sysctl_pkg;
   typedef enum logic [2:0] {
      S_IDLE, S_RST_DRIVE, S_RST_WAIT, S_RST_VEC,
      S_STACK, S_VEC, S_PREFETCH, S_POP
   } seq_state_type;

   typedef struct packed {
      seq_state_type       state;
      logic [1:0]          phase;
      logic [7:0]          cnt;
      logic [20:0]         wdog;
      logic [5:0]          cause;
      logic                opt_en;
      logic                opt_tsel;
      logic                opt_lock;
      logic [`SRC_MAX-1:0] flag;
      logic [`SRC_MAX-1:0] ien;
      logic [15:0]         vec;
      logic [15:0]         pc;
      logic [15:0]         sp;
      logic [7:0]          condition_code_register;
      logic [7:0]          acc;
      logic [7:0]          xlo;
      logic [1:0]          lvd_sync;
      logic [1:0]          pin_sync;
      logic                pin_oe_n;
      logic                rst_active;
      logic                hold;
      logic                load;
      logic [7:0]          pf_data;
      logic                pf_valid;
      logic [15:0]         mem_addr;
      logic [7:0]          mem_wdata;
      logic                mem_we;
      logic                mem_re;
      logic                wait_req;
      logic [31:0]         rdata;
   } ctl_state_type;
endpackage

// file: test/mem_pin_model.sv
module mem_pin_model (
   input  wire logic        clk_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        we_i,
   input  wire logic        re_i,
   input  wire logic        pin_oe_n_i,
   input  wire logic        ext_low_i,
   output logic      [7:0]  rdata_o,
   output logic             pin_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:65535];
   initial begin
      for (int i = 0; i < 65536; i++)
         mem[i] = 8'(i ^ (i >> 8));
   end
   // data stands one cycle only, then scrambles so a late capture shows up
   always @(posedge clk_i) begin
      if (we_i)
         mem[addr_i] <= wdata_i;
      rdata_o <= re_i ? mem[addr_i] : ~rdata_o;
   end
   // open drain with pullup: low while either party pulls
   assign pin_o = pin_oe_n_i & ~ext_low_i;
endmodule

// file: test/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i, rst_n_i, rd, wr, done, ret, ilop, ilad, bdm, ext_low, pin;
   logic        wq, hold, load, ract, oe_n, pf_v, we, re, software_interrupt_instr, low_voltage_detect, bdmr;
   logic [7:0]  adr, cc, a, x, mrd, cc_o, a_o, x_o, wdat, src, pfd;
   logic [15:0] pc, stk, pc_o, stk_o, maddr;
   logic [31:0] wd, rdv, q;
   int          failures, tests_run, oe_low, pf_n;

   reset_watchdog_interrupt_control #(.COP_SHORT(64), .COP_LONG(256)) dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdv),
      .avs_waitrequest_o(wq), .core_pc_i(pc), .core_sp_i(stk), .core_ccr_i(cc),
      .core_a_i(a), .core_x_i(x), .instr_done_i(done), .swi_i(software_interrupt_instr),
      .rti_i(ret), .illegal_op_i(ilop), .illegal_addr_i(ilad),
      .bdm_active_i(bdm), .bdm_reset_i(bdmr), .lvd_i(low_voltage_detect), .rst_pin_i(pin),
      .src_event_i(src), .mem_rdata_i(mrd), .rst_pin_o(), .rst_pin_oe_n_o(oe_n),
      .reset_active_o(ract), .core_hold_o(hold), .core_load_o(load),
      .core_pc_o(pc_o), .core_sp_o(stk_o), .core_ccr_o(cc_o), .core_a_o(a_o),
      .core_x_o(x_o), .pf_data_o(pfd), .pf_valid_o(pf_v), .mem_addr_o(maddr),
      .mem_wdata_o(wdat), .mem_we_o(we), .mem_re_o(re));
   mem_pin_model pm (.clk_i(clk_i), .addr_i(maddr), .wdata_i(wdat), .we_i(we),
      .re_i(re), .pin_oe_n_i(oe_n), .ext_low_i(ext_low), .rdata_o(mrd), .pin_o(pin));

   function automatic logic [7:0] m(input logic [15:0] ad);
      return ad[15:8] ^ ad[7:0];
   endfunction
   task automatic print_verdict;
      if (failures == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic hang(input string n);
      chk(n, 0, 1);
      print_verdict();
   endtask
   task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int i;
      @(posedge clk_i);
      adr <= ad;
      wr <= w;
      rd <= ~w;
      wd <= d;
      for (i = 0; i < 20; i++) begin
         @(posedge clk_i);
         if (wq === 1'b0) break;
      end
      q = rdv;
      rd <= 1'b0;
      wr <= 1'b0;
      if (i == 20) hang("bus");
   endtask
   task automatic wait_load(input int lim);
      int i;
      oe_low = 0;
      pf_n = 0;
      for (i = 0; i < lim; i++) begin
         @(posedge clk_i);
         if (oe_n === 1'b0) begin
            oe_low++;
            chk("quiet", ract, 1);
         end
         pf_n += int'(pf_v === 1'b1);
         if (load === 1'b1) break;
      end
      if (i == lim) hang("load");
   endtask
   task automatic after_reset(input int lim, input logic [31:0] cause);
      wait_load(lim);
      chk("drive", oe_low, 34);
      chk("pc", pc_o, {m(16'hfffe), m(16'hffff)});
      chk("stk", stk_o, 16'h00ff);
      chk("cc", cc_o, 8'h08);
      bus(0, 8'h00, 0);
      chk("cause", q, cause);
      bus(0, 8'h04, 0);
      chk("opt", q, 3);
   endtask
   // k[0] marks a return instruction, k[1] a software interrupt
   task automatic pulse(input logic [1:0] k);
      @(posedge clk_i);
      done <= 1'b1;
      ret <= k[0];
      software_interrupt_instr <= k[1];
      @(posedge clk_i);
      done <= 1'b0;
      ret <= 1'b0;
      software_interrupt_instr <= 1'b0;
   endtask

   initial begin
      clk_i = 0;
      forever #20 clk_i = ~clk_i;
   end
   initial begin
      {rst_n_i, rd, wr, done, ret, ilop, ilad, bdm, ext_low, software_interrupt_instr, low_voltage_detect, bdmr} = '0;
      {adr, wd, src, pc, stk, cc, a, x} = {8'h00, 32'h0, 8'h00, 16'h1234, 16'h0080,
         8'h08, 8'ha5, 8'h3c};
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      after_reset(200, 1);
      bus(1, 8'h04, 1); // lock in with the short period
      bus(1, 8'h04, 0);
      bus(0, 8'h04, 0);
      chk("lock", q, 32'h81);
      repeat (6) begin
         repeat (30) @(posedge clk_i);
         bus(1, 8'h00, 32'hff);
      end
      bdm <= 1'b1;
      repeat (300) @(posedge clk_i);
      bdm <= 1'b0;
      chk("alive", ract, 0);
      // a watchdog reset in between would have left its own cause behind
      bus(0, 8'h00, 0);
      chk("no cop", q, 1);
      after_reset(200, 4);
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_i);
         ilop <= (k == 0);
         ilad <= (k == 1);
         low_voltage_detect <= (k == 2);
         bdmr <= (k == 3);
         @(posedge clk_i);
         {ilop, ilad, low_voltage_detect, bdmr} <= 4'h0;
         after_reset(200, (k < 2) ? 32'h8 << k : (k == 2) ? 32'h2 : 32'h0);
      end
      ext_low <= 1'b1;
      fork
         begin
            repeat (150) @(posedge clk_i);
            ext_low <= 1'b0;
         end
      join_none
      after_reset(300, 32'h20);
      bus(0, 8'h40, 0);
      chk("unmapped", q, 0);
      bus(1, 8'h04, 0); // watchdog off for the long interrupt sequence
      bus(1, 8'h0c, 6);
      @(posedge clk_i);
      // source 0 flags too but stays disabled, so source 1 must win
      src <= 8'h07;
      @(posedge clk_i);
      src <= 8'h00;
      bus(0, 8'h08, 0);
      chk("flags", q, 7);
      pulse(0);
      repeat (3) @(posedge clk_i);
      chk("masked", hold, 0);
      cc <= 8'h00;
      pulse(0);
      wait_load(100);
      chk("fill", pf_n, 3);
      chk("vec", pc_o, {m(16'hfff8), m(16'hfff9)});
      chk("stk", stk_o, stk - 5);
      chk("mask", cc_o, 8'h08);
      chk("pf", pfd, m(16'h0708));
      cc <= 8'h08;
      stk <= stk - 5;
      pulse(1);
      wait_load(100);
      chk("rpc", pc_o, 16'h1234);
      chk("rcc", cc_o, 8'h00);
      chk("ra", a_o, 8'ha5);
      chk("rx", x_o, 8'h3c);
      pulse(2);
      wait_load(100);
      chk("swi", pc_o, {m(16'hfffc), m(16'hfffd)});
      chk("sfill", pf_n, 3);
      chk("ssp", stk_o, stk - 5);
      print_verdict();
   end
endmodule
